//--- bench/rwcd_assertions.sv
// assertion checker for setting write and carrier detect
module rwcd_assertions
	import rwcd_pkg::*;
#(parameter int NUM_SREGS = 16) (
	// clock, reset, watched ports
	input wire logic sys_clk,
	input wire logic rst,
	input wire rwcd_axi_req_s axi_req,
	input wire rwcd_axi_rsp_s axi_rsp,
	input wire rwcd_cond_s cond,
	input wire logic dcd_active
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic st_q;
	logic [2:0] m_q;
	wire st_rd = axi_rsp.rvalid && st_q;
	// option as last read back; any write makes it unknown until reread
	always_ff @(posedge sys_clk) begin
		if (rst) m_q <= 3'h1;
		else if (axi_req.awvalid && axi_rsp.awready) m_q <= 3'h7;
		else if (st_rd && axi_req.rready) m_q <= axi_rsp.rdata[18:16];
		if (axi_req.arvalid && axi_rsp.arready) st_q <= axi_req.araddr[7:0] == 8'h0C;
	end
	sequence s_wr;
		axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
	endsequence
	property p_c0; m_q == 3'h0 |-> dcd_active; endproperty
	a_c0: assert property (p_c0) else $error("dcd off");
	property p_c1; m_q == 3'h1 && !$past(rst) |-> dcd_active == $past(cond[2]); endproperty
	a_c1: assert property (p_c1) else $error("dcd vs link");
	property p_c3; m_q == 3'h3 |-> dcd_active == $past(cond[1]); endproperty
	a_c3: assert property (p_c3) else $error("dcd vs coverage");
	property p_c4; m_q == 3'h4 |-> dcd_active == $past(cond[0]); endproperty
	a_c4: assert property (p_c4) else $error("dcd vs registration");
	property p_opt; st_rd |-> axi_rsp.rdata[18:16] inside {3'h0, 3'h1, 3'h3, 3'h4}; endproperty
	a_opt: assert property (p_opt) else $error("bad option");
	property p_sel; st_rd |-> axi_rsp.rdata[13:8] < NUM_SREGS; endproperty
	a_sel: assert property (p_sel) else $error("bad selection");
	property p_b; s_wr |-> ##2 axi_rsp.bvalid; endproperty
	a_b: assert property (p_b) else $error("late answer");
	property p_one; axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready; endproperty
	a_one: assert property (p_one) else $error("write overlap");
endmodule

//--- bench/rwcd_cond_model.sv
// radio-side condition source for the bench
module rwcd_cond_model
	import rwcd_pkg::*;
(
	// clock and next conditions
	input wire logic sys_clk,
	input wire logic [2:0] pat,
	output rwcd_cond_s cond
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] q = 3'h0;
	// conditions move only at the clock edge
	always @(posedge sys_clk) q <= pat;
	assign cond = q;
endmodule

//--- bench/testbench.sv
// bench for setting write and carrier detect
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import rwcd_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic dcd_active;
	logic [2:0] pat = 3'h0;
	logic [2:0] e_mode = 3'h1;
	logic [5:0] e_sel = 6'h0;
	logic [31:0] seed = 32'hBA37;
	logic [65:0] e;
	logic [1:0] bq[$];
	logic [65:0] rq[$];
	int bad_count = 0;
	int checked = 0;
	rwcd_axi_req_s req = '0;
	rwcd_axi_rsp_s rsp;
	rwcd_cond_s cond;
	rwcd_top dut_u (.sys_clk(sys_clk), .rst(rst), .axi_req(req), .axi_rsp(rsp), .cond(cond),
		.dcd_active(dcd_active));
	rwcd_cond_model cm_u (.sys_clk(sys_clk), .pat(pat), .cond(cond));
	// 50 MHz clock
	always #10 sys_clk = ~sys_clk;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic dx(input logic [2:0] v);
		return e_mode == 3'h0 ? 1'b1 : e_mode == 3'h1 ? v[2] : e_mode == 3'h3 ? v[1] : v[0];
	endfunction
	task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] x);
		checked++;
		if (s !== x) begin
			bad_count++;
			$display("FAIL %s exp %h seen %h", nm, x, s);
		end
	endtask
	task automatic print_verdict(input bit t);
		if (t) bad_count++;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// one bus access; x holds {resp, read mask, data}, noted before it starts
	task automatic bus(input bit w, input logic [7:0] a, input logic [65:0] x);
		int n;
		if (w) bq.push_back(x[65:64]);
		else rq.push_back(x);
		@(posedge sys_clk);
		req.awaddr <= {24'h0, a};
		req.araddr <= {24'h0, a};
		req.wdata <= x[31:0];
		req.wstrb <= 4'hF;
		req.awvalid <= w;
		req.wvalid <= w;
		req.bready <= w;
		req.arvalid <= !w;
		req.rready <= !w;
		for (n = 0; n < 99; n++) begin
			@(posedge sys_clk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
			if (rsp.arready) req.arvalid <= 1'b0;
			if (rsp.bvalid || rsp.rvalid) break;
		end
		req.bready <= 1'b0;
		req.rready <= 1'b0;
		if (n == 99) print_verdict(1'b1);
	endtask
	// answers are matched against the oldest note
	always @(posedge sys_clk) begin
		if (rsp.bvalid && req.bready) chk("bresp", 34'(rsp.bresp), 34'(bq.pop_front()));
		if (rsp.rvalid && req.rready) begin
			e = rq.pop_front();
			chk("rdata", {rsp.rresp, rsp.rdata & e[63:32]}, {e[65:64], e[31:0]});
		end
	end
	// value characters, execute, then status with result, selection, option
	task automatic cmd(input logic [1:0] op, input logic [7:0] n, input string v,
		input logic [1:0] r);
		for (int i = 0; i < v.len(); i++) bus(1'b1, 8'h08, {34'h0, 24'h0, v[i]});
		bus(1'b1, 8'h04, {34'h0, 1'b1, 15'h0, n, 6'h0, op});
		if (op == 2'h0 && n < 8'h10) e_sel = n[5:0];
		if (op == 2'h2 && r == 2'h1) e_mode = 3'(v.atoi());
		bus(1'b0, 8'h0C, {34'h0_0007_3F03, 13'h0, e_mode, 2'h0, e_sel, 6'h0, r});
	endtask
	// random conditions; carrier detect lags them by two edges through the model
	task automatic drun();
		logic [2:0] h1;
		logic [2:0] h2;
		logic [2:0] x;
		h1 = pat;
		h2 = pat;
		repeat (12) begin
			@(posedge sys_clk);
			x = 3'(xs());
			pat <= x;
			#1;
			chk("dcd", 34'(dcd_active), 34'(dx(h2)));
			h2 = h1;
			h1 = x;
		end
	endtask
	// reset, then the command sequence
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		cmd(2'h0, 8'h04, "7", 2'h1);
		cmd(2'h0, 8'h03, "123", 2'h1);
		cmd(2'h1, 8'h00, "45", 2'h1);
		bus(1'b0, 8'h4C, 66'h0_FFFF_FFFF_0000_002D);
		bus(1'b0, 8'h50, 66'h0_FFFF_FFFF_0000_0007);
		cmd(2'h0, 8'h05, "1A", 2'h2);
		cmd(2'h0, 8'h06, "256", 2'h2);
		cmd(2'h0, 8'h00, "1", 2'h2);
		bus(1'b1, 8'h40, {2'h2, 32'h0, 32'h0000_0055});
		bus(1'b0, 8'h40, 66'h0_FFFF_FFFF_0000_0000);
		cmd(2'h0, 8'h0E, "2", 2'h3);
		bus(1'b1, 8'h00, 66'h1);
		cmd(2'h1, 8'h00, "2", 2'h1);
		bus(1'b0, 8'h78, 66'h0_FFFF_FFFF_0000_0002);
		cmd(2'h0, 8'h0F, "AWXYZ", 2'h1);
		bus(1'b0, 8'h7C, 66'h0_FFFF_FFFF_5758_595A);
		cmd(2'h0, 8'h14, "1", 2'h2);
		cmd(2'h3, 8'h00, "", 2'h2);
		bus(1'b0, 8'h30, 66'h2_FFFF_FFFF_0000_0000);
		for (int i = 0; i < 10; i++) begin
			cmd(2'h2, 8'h00, $sformatf("%0d", i), i inside {0, 1, 3, 4} ? 2'h1 : 2'h2);
			drun();
			bus(1'b0, 8'h10, {34'h0_0000_0007, 29'h0, pat});
		end
		print_verdict(1'b0);
	end
endmodule
bind rwcd_top rwcd_assertions #(.NUM_SREGS(NUM_SREGS)) ac_u (.sys_clk(sys_clk), .rst(rst),
	.axi_req(axi_req), .axi_rsp(axi_rsp), .cond(cond), .dcd_active(dcd_active));

//--- hdl/rwcd_top.sv
// setting-register write command interpreter with carrier detect selection
//
// What this block does
// - write named register, or last named one
// - unnumbered write touches only selected register
// - value taken as number or text per register
// - numeric values parsed as decimal digits
// - bad value, out-of-range register number or read-only gives error, else OK
// - privileged registers need provider mode, else refused
// - option selects what carrier detect output shows
// - option 0 holds carrier detect always active
// - option 1, default, follows connection established
// - option 3 follows radio in coverage
// - option 4 follows network registration
// - explicit in-range register number updates the selection
//
// usage: one CHAR write per value character, then CMD with execute set
// value buffer clears on every execute, so no residue reaches the next command
// numeric values stop at 255; longer digit strings give ERROR, never a wrap
// text registers keep the last four characters, newest in the low byte
// line-end placement of text values is the host's; no line concept here
// only the low eight address bits decode, so higher bits alias
// dcd_active lags its condition or a new option by one clock
// results overwrite per command; there is no sticky flag to clear
`include "rwcd_map.svh"

module rwcd_top
	import rwcd_pkg::*;
#(
	parameter int NUM_SREGS = 16,
	parameter logic [47:0] TEXT_MASK = 48'h0000_0000_8000,
	parameter logic [47:0] RO_MASK = 48'h0000_0000_0001,
	parameter logic [47:0] PRIV_MASK = 48'h0000_0000_4000
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// register bus
	input wire rwcd_axi_req_s axi_req,
	output rwcd_axi_rsp_s axi_rsp,
	// modem conditions
	input wire rwcd_cond_s cond,
	// serial port carrier detect, high while active
	output logic dcd_active
);

	// the window at 0x40 reaches at most 48 words inside the low eight address bits
	// elaboration refuses counts that would alias or leave no register
	if (NUM_SREGS < 1 || NUM_SREGS > 48) begin : g_num_sregs_bad
		$error("NUM_SREGS must lie between 1 and 48");
	end

	typedef struct packed {
		rwcd_axi_rsp_s rsp;
		rwcd_wst_e wst;
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic priv_mode;
		logic [5:0] sel;
		logic [15:0] acc;
		logic bad;
		logic [31:0] text;
		logic [2:0] dcd_mode;
		logic dcd;
		rwcd_res_e result;
		logic [3:0] seq;
		logic [47:0][31:0] sreg;
	} rwcd_state_s;

	rwcd_state_s q;
	rwcd_state_s d;

	// helper values of the write and read decode
	logic [7:0] wr_ch;
	logic ch_digit;
	logic [19:0] acc_next;
	rwcd_op_e op;
	logic [7:0] cmd_reg;
	logic [5:0] tgt;
	logic tgt_ok;
	logic [7:0] rd_addr;
	logic [5:0] rd_idx;

	// one pass computes the whole next state; the flops below take it
	always_comb begin
		d = q;
		wr_ch = q.wdata[7:0];
		ch_digit = (wr_ch >= `RWCD_ASCII_ZERO) && (wr_ch <= `RWCD_ASCII_NINE);
		acc_next = ({4'h0, q.acc} * 20'h0000A) + {16'h0, wr_ch[3:0]};
		op = rwcd_op_e'(q.wdata[`RWCD_CMD_OP_LSB +: 2]);
		cmd_reg = q.wdata[`RWCD_CMD_REG_LSB +: 8];
		tgt = q.sel;
		tgt_ok = 1'b1;
		rd_addr = axi_req.araddr[7:0];
		rd_idx = rd_addr[7:2] - 6'h10;

		// capture address and data in either order
		if (q.rsp.awready && axi_req.awvalid) begin
			d.aw_have = 1'b1;
			d.aw_addr = axi_req.awaddr[7:0];
		end
		if (q.rsp.wready && axi_req.wvalid) begin
			d.w_have = 1'b1;
			d.wdata = axi_req.wdata;
			d.wstrb = axi_req.wstrb;
		end

		case (q.wst)
			RWCD_WS_IDLE: begin
				if (q.aw_have && q.w_have) begin
					d.aw_have = 1'b0;
					d.w_have = 1'b0;
					d.wst = RWCD_WS_RESP;
					d.rsp.bvalid = 1'b1;
					d.rsp.bresp = `RWCD_RESP_OKAY;
					// CTRL, CHAR and CMD act; STATUS and COND swallow the write
					case (q.aw_addr)
						`RWCD_OFS_CTRL: begin
							// privilege stays until software clears it
							if (q.wstrb[0]) begin
								d.priv_mode = q.wdata[`RWCD_CTRL_PRIV_BIT];
							end
						end
						`RWCD_OFS_CHAR: begin
							if (q.wstrb[0]) begin
								// a non-digit or overflow stays flagged until execute
								// decimal digit accumulate
								if (!ch_digit) begin
									d.bad = 1'b1;
								end else if (acc_next > {4'h0, `RWCD_NUM_MAX}) begin
									d.bad = 1'b1;
								end else begin
									d.acc = acc_next[15:0];
								end
								// text keeps the last four characters, oldest on top
								d.text = {q.text[23:0], wr_ch};
							end
						end
						`RWCD_OFS_CMD: begin
							// partial strobes never execute, so a split word cannot fire
							if (q.wdata[`RWCD_CMD_EXEC_BIT] && (&q.wstrb)) begin
								d.seq = q.seq + 4'h1;
								// parse state always starts fresh for the next command
								d.acc = 16'h0000;
								d.bad = 1'b0;
								d.text = 32'h0000_0000;
								case (op)
									RWCD_OP_NUMBERED, RWCD_OP_SELECTED: begin
										if (op == RWCD_OP_NUMBERED) begin
											tgt = cmd_reg[5:0];
											tgt_ok = (cmd_reg < 8'(NUM_SREGS));
											// an out-of-range number keeps the old selection
											// explicit number selects
											if (tgt_ok) begin
												d.sel = cmd_reg[5:0];
											end
										end
										// order: range, privilege, read only, type, value
										if (!tgt_ok) begin
											d.result = RWCD_RES_ERROR;
										end else if (PRIV_MASK[tgt] && !q.priv_mode) begin
											d.result = RWCD_RES_NOT_ENABLED;
										end else if (RO_MASK[tgt]) begin
											d.result = RWCD_RES_ERROR;
										end else if (TEXT_MASK[tgt]) begin
											// text is stored as typed; digits not required
											// only target changes
											d.sreg[tgt] = q.text;
											d.result = RWCD_RES_OK;
										end else if (q.bad) begin
											d.result = RWCD_RES_ERROR;
										end else begin
											d.sreg[tgt] = {16'h0000, q.acc};
											d.result = RWCD_RES_OK;
										end
									end
									RWCD_OP_CARRIER: begin
										if (!q.bad && (q.acc == 16'(`RWCD_DCD_ALWAYS)
											|| q.acc == 16'(`RWCD_DCD_CONN)
											|| q.acc == 16'(`RWCD_DCD_RANGE)
											|| q.acc == 16'(`RWCD_DCD_REGD))) begin
											d.dcd_mode = q.acc[2:0];
											d.result = RWCD_RES_OK;
										end else begin
											d.result = RWCD_RES_ERROR;
										end
									end
									default: begin
										d.result = RWCD_RES_ERROR;
									end
								endcase
							end
						end
						`RWCD_OFS_STATUS, `RWCD_OFS_COND: begin
							// read-only registers ignore writes
						end
						default: begin
							// setting registers are written by command only
							d.rsp.bresp = `RWCD_RESP_SLVERR;
						end
					endcase
				end
			end
			// answer held until the master takes it; no new beat meanwhile
			RWCD_WS_RESP: begin
				if (axi_req.bready) begin
					d.rsp.bvalid = 1'b0;
					d.wst = RWCD_WS_IDLE;
				end
			end
			default: begin
				d.wst = RWCD_WS_IDLE;
			end
		endcase

		// new requests wait until the pending write has been answered
		d.rsp.awready = !d.aw_have && (d.wst == RWCD_WS_IDLE);
		d.rsp.wready = !d.w_have && (d.wst == RWCD_WS_IDLE);

		// read channel, one beat, answered one cycle after the address
		if (q.rsp.rvalid && axi_req.rready) begin
			d.rsp.rvalid = 1'b0;
		end
		if (q.rsp.arready && axi_req.arvalid) begin
			d.rsp.rvalid = 1'b1;
			d.rsp.rresp = `RWCD_RESP_OKAY;
			d.rsp.rdata = 32'h0000_0000;
			// unused control and status bits read as zero
			case (rd_addr)
				`RWCD_OFS_CTRL: begin
					d.rsp.rdata[`RWCD_CTRL_PRIV_BIT] = q.priv_mode;
				end
				`RWCD_OFS_CMD, `RWCD_OFS_CHAR: begin
					d.rsp.rdata = 32'h0000_0000;
				end
				// last result, command count, selection, option, pin
				`RWCD_OFS_STATUS: begin
					d.rsp.rdata[`RWCD_ST_RES_LSB +: 2] = q.result;
					d.rsp.rdata[`RWCD_ST_SEQ_LSB +: 4] = q.seq;
					d.rsp.rdata[`RWCD_ST_SEL_LSB +: 6] = q.sel;
					d.rsp.rdata[`RWCD_ST_MODE_LSB +: 3] = q.dcd_mode;
					d.rsp.rdata[`RWCD_ST_DCD_BIT] = q.dcd;
				end
				`RWCD_OFS_COND: begin
					d.rsp.rdata[2:0] = cond;
				end
				default: begin
					// setting window is read here only; commands are its sole writer
					if (rd_addr >= `RWCD_OFS_SREG_BASE && rd_addr[1:0] == 2'h0
						&& rd_idx < 6'(NUM_SREGS)) begin
						d.rsp.rdata = q.sreg[rd_idx];
					end else begin
						d.rsp.rresp = `RWCD_RESP_SLVERR;
					end
				end
			endcase
		end
		// one read in flight; arready returns the cycle after rready
		d.rsp.arready = !d.rsp.rvalid;

		case (q.dcd_mode)
			`RWCD_DCD_ALWAYS: d.dcd = 1'b1;
			`RWCD_DCD_CONN: d.dcd = cond.conn_established;
			`RWCD_DCD_RANGE: d.dcd = cond.radio_in_coverage;
			`RWCD_DCD_REGD: d.dcd = cond.net_registered;
			// unlisted codes never reach the option register
			default: d.dcd = 1'b0;
		endcase
	end

	// state register; option 1 is the power-on carrier detect behaviour
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '0;
			q.dcd_mode <= `RWCD_DCD_RST;
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state flops
	assign axi_rsp = q.rsp;
	// registered copy, so the pin never glitches on a decode change
	assign dcd_active = q.dcd;

endmodule

//--- inc/rwcd_map.svh
// register offsets, field positions, reset values and limits of the command block
`ifndef RWCD_MAP_SVH
`define RWCD_MAP_SVH

// register byte offsets (low eight address bits)
`define RWCD_OFS_CTRL 8'h00
`define RWCD_OFS_CMD 8'h04
`define RWCD_OFS_CHAR 8'h08
`define RWCD_OFS_STATUS 8'h0C
`define RWCD_OFS_COND 8'h10
`define RWCD_OFS_SREG_BASE 8'h40

// control register fields
`define RWCD_CTRL_PRIV_BIT 0

// command register fields
`define RWCD_CMD_OP_LSB 0
`define RWCD_CMD_REG_LSB 8
`define RWCD_CMD_EXEC_BIT 31

// status register fields
`define RWCD_ST_RES_LSB 0
`define RWCD_ST_SEQ_LSB 4
`define RWCD_ST_SEL_LSB 8
`define RWCD_ST_MODE_LSB 16
`define RWCD_ST_DCD_BIT 24

// carrier detect option values
`define RWCD_DCD_ALWAYS 3'h0
`define RWCD_DCD_CONN 3'h1
`define RWCD_DCD_RANGE 3'h3
`define RWCD_DCD_REGD 3'h4
`define RWCD_DCD_RST `RWCD_DCD_CONN

// parsing limits and bus answers
`define RWCD_ASCII_ZERO 8'h30
`define RWCD_ASCII_NINE 8'h39
`define RWCD_NUM_MAX 16'h00FF
`define RWCD_RESP_OKAY 2'h0
`define RWCD_RESP_SLVERR 2'h2

`endif

//--- inc/rwcd_pkg.sv
// types shared by the setting-register write and carrier detect block
package rwcd_pkg;

	// command opcodes
	typedef enum logic [1:0] {
		RWCD_OP_NUMBERED = 2'h0,
		RWCD_OP_SELECTED = 2'h1,
		RWCD_OP_CARRIER = 2'h2,
		RWCD_OP_RSVD = 2'h3
	} rwcd_op_e;

	// result codes returned to the host
	typedef enum logic [1:0] {
		RWCD_RES_NONE = 2'h0,
		RWCD_RES_OK = 2'h1,
		RWCD_RES_ERROR = 2'h2,
		RWCD_RES_NOT_ENABLED = 2'h3
	} rwcd_res_e;

	// write channel state
	typedef enum logic {
		RWCD_WS_IDLE = 1'b0,
		RWCD_WS_RESP = 1'b1
	} rwcd_wst_e;

	// bus master to block
	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic rready;
	} rwcd_axi_req_s;

	// block to bus master
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} rwcd_axi_rsp_s;

	// conditions the carrier detect output can follow
	typedef struct packed {
		logic conn_established;
		logic radio_in_coverage;
		logic net_registered;
	} rwcd_cond_s;

endpackage
